// *** src/rdld_decoder.v ***
// Notes on behaviour
// R01 - Top header byte selects command type.
// R02 - Decode pixel and line command field codes; only the line codes are decoded here, pixel types ignore the command field.
// R03 - Decode second-group command field codes.
// R04 - Interrupt header pulses host request, continues.
// R05 - Sync waits for vertical blank if flagged.
// R06 - Register set writes counted consecutive registers.
// R07 - Unpacked vertex loads X, Y into vertex.
// R08 - Shape begin starts bounding rectangle tracking.
// R09 - Packed vertex: one word, Y high, X low.
// R10 - Shape end fills shape using rectangle.
// R11 - Frame-buffer flush writes pending pixels out.
// R12 - Depth flush writes pending depth values out.
// R13 - Pixel plot takes X, Y words.
// R14 - Depth pixel plot takes X, Y, Z words.
// R15 - Line takes five words, then draws.
// R16 - Axis bit picks X or Y principal.
// R17 - No-end variants omit the final pixel.
// R18 - Pattern-clear variants reset pattern position first.
// R19 - Anti-aliased variants keep other line behaviour.
// R20 - Parameter words land in rendering registers.
// R21 - Host loads needed registers before drawing.
// R22 - Unknown types are no-ops without parameters.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`include "rdld_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module rdld_decoder (
    input  wire        ref_clk_i,
    input  wire        reset_i,
    // Classic Wishbone slave.
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Display-list word stream.
    input  wire        dl_valid_i,
    input  wire [31:0] dl_data_i,
    output wire        dl_ready_o,
    // Vertical sync pin.
    input  wire        vsync_i,
    // Events toward host and pipeline.
    output reg         host_irq_o,
    output reg         fb_flush_o,
    output reg         z_flush_o,
    // Register-set write port.
    output reg         reg_we_o,
    output reg  [15:0] reg_addr_o,
    output reg  [31:0] reg_data_o,
    // Pixel registers.
    output reg  [31:0] pixel_x_start_o,
    output reg  [31:0] pixel_y_start_o,
    output reg  [31:0] pixel_z_value_o,
    // Line registers.
    output reg  [31:0] line_pattern_word_o,
    output reg  [31:0] line_x_start_o,
    output reg  [31:0] line_x_delta_o,
    output reg  [31:0] line_y_start_o,
    output reg  [31:0] line_y_delta_o,
    output reg         line_axis_y_o,
    output reg         line_no_end_o,
    output reg         line_anti_alias_o,
    output reg         pattern_clear_o,
    // Draw start.
    output reg         draw_go_o,
    output reg  [1:0]  draw_kind_o,
    // Vertex register write.
    output reg         vtx_we_o,
    output reg  [3:0]  vtx_sel_o,
    output reg  [15:0] vtx_x_o,
    output reg  [15:0] vtx_y_o,
    // Bounding rectangle of the current shape.
    output reg  [15:0] bbox_xmin_o,
    output reg  [15:0] bbox_xmax_o,
    output reg  [15:0] bbox_ymin_o,
    output reg  [15:0] bbox_ymax_o,
    output reg         shape_active_o
);

    // One-hot decoder states.
    localparam [2:0] ST_HDR = 3'b001;
    localparam [2:0] ST_PAR = 3'b010;
    localparam [2:0] ST_VSW = 3'b100;

    reg  [2:0]  state_r;
    reg  [7:0]  hdr_type_r;
    reg  [7:0]  hdr_cmd_r;
    reg  [15:0] hdr_addr_r;
    reg  [3:0]  hdr_vtx_r;
    reg  [7:0]  param_idx_r;
    reg  [7:0]  param_left_r;
    reg  [15:0] vx_hold_r;
    reg         line_ok_r;
    reg         go_pend_r;
    reg  [1:0]  go_kind_r;
    reg  [31:0] ctrl_r;
    reg  [31:0] cmd_cnt_r;
    reg         vs_meta_r;
    reg         vs_sync_r;
    reg         vs_prev_r;

    wire [7:0]  typ = dl_data_i[31:24];
    wire [7:0]  cmd = dl_data_i[23:16];
    wire        take;
    wire        vs_rise;
    wire        last_par;

    // Words are taken only while enabled and not waiting for sync.
    assign dl_ready_o = ctrl_r[`RDLD_CTRL_EN] & ~state_r[2];
    assign take       = dl_valid_i & dl_ready_o;
    assign vs_rise    = vs_sync_r & ~vs_prev_r;
    assign last_par   = (param_left_r == 8'h01);

    // Two flip-flops bring the sync pin into the clock domain.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vs_meta_r <= 1'b0;
            vs_sync_r <= 1'b0;
            vs_prev_r <= 1'b0;
        end else begin
            vs_meta_r <= vsync_i;
            vs_sync_r <= vs_meta_r;
            vs_prev_r <= vs_sync_r;
        end
    end

    // Vertex commit, computed from the word being taken.
    reg         vc_we;
    reg  [15:0] vc_x;
    reg  [15:0] vc_y;
    always @* begin
        vc_we = 1'b0;
        vc_x  = vx_hold_r;
        vc_y  = dl_data_i[31:16];
        if (take && state_r[1]) begin
            if (hdr_type_r == `RDLD_TYPE_VTX && param_idx_r == 8'h01) begin
                vc_we = 1'b1; // see R07
            end else if (hdr_type_r == `RDLD_TYPE_VTXP) begin
                vc_we = 1'b1; // see R09
                vc_x  = dl_data_i[15:0];
            end
        end
    end

    // Header decode and parameter sequencing.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r             <= ST_HDR;
            hdr_type_r          <= `RDLD_TYPE_NOP;
            hdr_cmd_r           <= 8'h00;
            hdr_addr_r          <= 16'h0000;
            hdr_vtx_r           <= 4'h0;
            param_idx_r         <= 8'h00;
            param_left_r        <= 8'h00;
            vx_hold_r           <= 16'h0000;
            line_ok_r           <= 1'b0;
            go_pend_r           <= 1'b0;
            go_kind_r           <= `RDLD_KIND_PIXEL;
            cmd_cnt_r           <= 32'h0000_0000;
            host_irq_o          <= 1'b0;
            fb_flush_o          <= 1'b0;
            z_flush_o           <= 1'b0;
            reg_we_o            <= 1'b0;
            reg_addr_o          <= 16'h0000;
            reg_data_o          <= 32'h0000_0000;
            pixel_x_start_o     <= 32'h0000_0000;
            pixel_y_start_o     <= 32'h0000_0000;
            pixel_z_value_o     <= 32'h0000_0000;
            line_pattern_word_o <= 32'h0000_0000;
            line_x_start_o      <= 32'h0000_0000;
            line_x_delta_o      <= 32'h0000_0000;
            line_y_start_o      <= 32'h0000_0000;
            line_y_delta_o      <= 32'h0000_0000;
            line_axis_y_o       <= 1'b0;
            line_no_end_o       <= 1'b0;
            line_anti_alias_o   <= 1'b0;
            pattern_clear_o     <= 1'b0;
            draw_go_o           <= 1'b0;
            draw_kind_o         <= `RDLD_KIND_PIXEL;
        end else begin
            host_irq_o      <= 1'b0;
            fb_flush_o      <= 1'b0;
            z_flush_o       <= 1'b0;
            reg_we_o        <= 1'b0;
            pattern_clear_o <= 1'b0;
            // A draw starts the cycle after its last parameter lands.
            draw_go_o       <= go_pend_r;
            draw_kind_o     <= go_kind_r;
            go_pend_r       <= 1'b0;
            if (state_r[2] && vs_rise) begin
                state_r <= ST_HDR; // see R05
            end
            if (take && state_r[0]) begin
                cmd_cnt_r    <= cmd_cnt_r + 32'h0000_0001;
                hdr_type_r   <= typ; // see R01
                hdr_cmd_r    <= cmd;
                hdr_addr_r   <= dl_data_i[15:0];
                hdr_vtx_r    <= dl_data_i[3:0];
                param_idx_r  <= 8'h00;
                param_left_r <= 8'h00;
                state_r      <= ST_HDR;
                if (typ == `RDLD_TYPE_PIXEL) begin
                    param_left_r <= `RDLD_NPAR_PIXEL; // see R13
                    state_r      <= ST_PAR;
                end else if (typ == `RDLD_TYPE_PIXELZ) begin
                    param_left_r <= `RDLD_NPAR_PIXELZ; // see R14
                    state_r      <= ST_PAR;
                end else if (typ == `RDLD_TYPE_LINE) begin
                    param_left_r <= `RDLD_NPAR_LINE; // see R15
                    state_r      <= ST_PAR;
                    // Only 001_0xxxx codes are plain line variants.
                    line_ok_r    <= (cmd[7:4] == `RDLD_CMD_LINE_GRP); // see R02
                end else if (typ == `RDLD_TYPE_VTX) begin
                    param_left_r <= `RDLD_NPAR_VTX;
                    state_r      <= ST_PAR;
                end else if (typ == `RDLD_TYPE_VTXP) begin
                    param_left_r <= `RDLD_NPAR_VTXP;
                    state_r      <= ST_PAR;
                end else if (typ == `RDLD_TYPE_SETREG) begin
                    param_left_r <= dl_data_i[23:16]; // see R06
                    if (dl_data_i[23:16] != 8'h00) begin
                        state_r <= ST_PAR;
                    end
                end else if (typ == `RDLD_TYPE_DRAW) begin
                    if (cmd == `RDLD_CMD_FB_FLUSH) begin
                        fb_flush_o <= 1'b1; // see R11, R03
                    end else if (cmd == `RDLD_CMD_Z_FLUSH) begin
                        z_flush_o <= 1'b1; // see R12
                    end else if (cmd == `RDLD_CMD_SHAPE_END) begin
                        go_pend_r <= 1'b1; // see R10
                        go_kind_r <= `RDLD_KIND_SHAPE;
                    end
                end else if (typ == `RDLD_TYPE_SYNC) begin
                    if (dl_data_i[`RDLD_SYNC_VBLANK]) begin
                        state_r <= ST_VSW; // see R05
                    end
                end else if (typ == `RDLD_TYPE_INTR) begin
                    host_irq_o <= 1'b1; // see R04
                end
                // Any other type code is a no-op with no words. see R22
            end else if (take && state_r[1]) begin
                param_idx_r  <= param_idx_r + 8'h01;
                param_left_r <= param_left_r - 8'h01;
                if (last_par) begin
                    state_r <= ST_HDR;
                end
                // Each parameter word lands in its rendering register.
                if (hdr_type_r == `RDLD_TYPE_PIXEL ||
                    hdr_type_r == `RDLD_TYPE_PIXELZ) begin
                    if (param_idx_r == 8'h00) begin
                        pixel_x_start_o <= dl_data_i; // see R20
                    end else if (param_idx_r == 8'h01) begin
                        pixel_y_start_o <= dl_data_i;
                    end else begin
                        pixel_z_value_o <= dl_data_i; // see R14
                    end
                    if (last_par) begin
                        go_pend_r <= 1'b1;
                        go_kind_r <= (hdr_type_r == `RDLD_TYPE_PIXEL) ?
                                     `RDLD_KIND_PIXEL : `RDLD_KIND_PIXELZ;
                    end
                end else if (hdr_type_r == `RDLD_TYPE_LINE) begin
                    if (param_idx_r == 8'h00) begin
                        line_pattern_word_o <= dl_data_i; // see R15
                    end else if (param_idx_r == 8'h01) begin
                        line_x_start_o <= dl_data_i;
                    end else if (param_idx_r == 8'h02) begin
                        line_x_delta_o <= dl_data_i;
                    end else if (param_idx_r == 8'h03) begin
                        line_y_start_o <= dl_data_i;
                    end else begin
                        line_y_delta_o <= dl_data_i;
                    end
                    // Pattern reset precedes the draw start by a cycle.
                    if (last_par && line_ok_r) begin
                        pattern_clear_o <= hdr_cmd_r[`RDLD_LINE_PCLEAR]; // see R18
                        // Mode bits change only here, so a following
                        // header cannot alter them under a pending start.
                        line_axis_y_o <=
                            hdr_cmd_r[`RDLD_LINE_AXIS_Y]; // see R16
                        line_no_end_o <=
                            hdr_cmd_r[`RDLD_LINE_NO_END]; // see R17
                        line_anti_alias_o <=
                            hdr_cmd_r[`RDLD_LINE_ANTI]; // see R19
                        go_pend_r       <= 1'b1; // see R15
                        go_kind_r       <= `RDLD_KIND_LINE;
                    end
                end else if (hdr_type_r == `RDLD_TYPE_SETREG) begin
                    reg_we_o   <= 1'b1; // see R06
                    reg_addr_o <= hdr_addr_r + {8'h00, param_idx_r};
                    reg_data_o <= dl_data_i;
                end else if (hdr_type_r == `RDLD_TYPE_VTX) begin
                    if (param_idx_r == 8'h00) begin
                        vx_hold_r <= dl_data_i[31:16]; // see R07
                    end
                end
            end
        end
    end

    // Vertex registers and circumscribed rectangle tracking.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vtx_we_o       <= 1'b0;
            vtx_sel_o      <= 4'h0;
            vtx_x_o        <= 16'h0000;
            vtx_y_o        <= 16'h0000;
            bbox_xmin_o    <= 16'h0000;
            bbox_xmax_o    <= 16'h0000;
            bbox_ymin_o    <= 16'h0000;
            bbox_ymax_o    <= 16'h0000;
            shape_active_o <= 1'b0;
        end else begin
            vtx_we_o <= vc_we;
            if (vc_we) begin
                vtx_sel_o <= hdr_vtx_r; // see R07
                vtx_x_o   <= vc_x;
                vtx_y_o   <= vc_y;
                if (hdr_cmd_r == `RDLD_CMD_SHAPE_BEGIN) begin
                    // A new shape restarts the rectangle at this vertex.
                    shape_active_o <= 1'b1; // see R08
                    bbox_xmin_o    <= vc_x;
                    bbox_xmax_o    <= vc_x;
                    bbox_ymin_o    <= vc_y;
                    bbox_ymax_o    <= vc_y;
                end else if (shape_active_o) begin
                    if ($signed(vc_x) < $signed(bbox_xmin_o)) begin
                        bbox_xmin_o <= vc_x; // see R08
                    end
                    if ($signed(vc_x) > $signed(bbox_xmax_o)) begin
                        bbox_xmax_o <= vc_x;
                    end
                    if ($signed(vc_y) < $signed(bbox_ymin_o)) begin
                        bbox_ymin_o <= vc_y;
                    end
                    if ($signed(vc_y) > $signed(bbox_ymax_o)) begin
                        bbox_ymax_o <= vc_y;
                    end
                end
            end else if (draw_go_o && draw_kind_o == `RDLD_KIND_SHAPE) begin
                shape_active_o <= 1'b0; // see R10
            end
        end
    end

    // Wishbone slave: one wait state, ack for any address.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r   <= `RDLD_CTRL_RST;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                if (wb_adr_i == `RDLD_OFS_CTRL) begin
                    wb_dat_o <= ctrl_r;
                    if (wb_we_i && wb_sel_i[0]) begin
                        ctrl_r[`RDLD_CTRL_EN] <= wb_dat_i[`RDLD_CTRL_EN];
                    end
                end else if (wb_adr_i == `RDLD_OFS_STATUS) begin
                    wb_dat_o <= {28'h000_0000, shape_active_o, state_r};
                end else if (wb_adr_i == `RDLD_OFS_BBOX_X) begin
                    wb_dat_o <= {bbox_xmax_o, bbox_xmin_o};
                end else if (wb_adr_i == `RDLD_OFS_BBOX_Y) begin
                    wb_dat_o <= {bbox_ymax_o, bbox_ymin_o};
                end else if (wb_adr_i == `RDLD_OFS_CMDCNT) begin
                    wb_dat_o <= cmd_cnt_r;
                end
            end
        end
    end

endmodule // rdld_decoder

`default_nettype wire

// *** src/rdld_regs.vh ***
`ifndef RDLD_REGS_VH
`define RDLD_REGS_VH

// Type field codes of a display-list header, bits 31 to 24.
`define RDLD_TYPE_PIXEL      8'h00
`define RDLD_TYPE_PIXELZ     8'h01
`define RDLD_TYPE_LINE       8'h02
`define RDLD_TYPE_VTX        8'h70
`define RDLD_TYPE_VTXP       8'h71
`define RDLD_TYPE_DRAW       8'hF0
`define RDLD_TYPE_SETREG     8'hF1
`define RDLD_TYPE_SYNC       8'hFC
`define RDLD_TYPE_INTR       8'hFD
`define RDLD_TYPE_NOP        8'hFF

// Command field codes, bits 23 to 16.
`define RDLD_CMD_PIXEL       8'h00
`define RDLD_CMD_PIXELZ      8'h01
`define RDLD_CMD_LINE_GRP    4'h2
`define RDLD_CMD_FB_FLUSH    8'hC1
`define RDLD_CMD_Z_FLUSH     8'hC2
`define RDLD_CMD_SHAPE_BEGIN 8'hE0
`define RDLD_CMD_SHAPE_END   8'hE1
`define RDLD_CMD_NORMAL      8'hFF

// Line variant bits inside the command field.
`define RDLD_LINE_AXIS_Y     0
`define RDLD_LINE_NO_END     1
`define RDLD_LINE_PCLEAR     2
`define RDLD_LINE_ANTI       3

// Sync flag bit for vertical blank wait.
`define RDLD_SYNC_VBLANK     0

// Parameter word counts.
`define RDLD_NPAR_PIXEL      8'h02
`define RDLD_NPAR_PIXELZ     8'h03
`define RDLD_NPAR_LINE       8'h05
`define RDLD_NPAR_VTX        8'h02
`define RDLD_NPAR_VTXP       8'h01

// Draw kinds reported with a draw start.
`define RDLD_KIND_PIXEL      2'h0
`define RDLD_KIND_PIXELZ     2'h1
`define RDLD_KIND_LINE       2'h2
`define RDLD_KIND_SHAPE      2'h3

// Wishbone register byte offsets.
`define RDLD_OFS_CTRL        8'h00
`define RDLD_OFS_STATUS      8'h04
`define RDLD_OFS_BBOX_X      8'h08
`define RDLD_OFS_BBOX_Y      8'h0C
`define RDLD_OFS_CMDCNT      8'h10

// Control register: bit 0 enables decoding.
`define RDLD_CTRL_EN         0
`define RDLD_CTRL_RST        32'h0000_0001

`endif

// *** tb/rdld_dl_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module rdld_dl_host (
    input  wire logic        ref_clk_i,
    input  wire logic        dl_ready_o,
    output var  logic        dl_valid_i,
    output var  logic [31:0] dl_data_i
);
    // Nothing is offered before the first word.
    initial begin
        dl_valid_i = 1'b0;
        dl_data_i  = 32'h0;
    end
    // Holds one word until the decoder takes it; lists carry every parameter
    // a draw needs before its header is followed.
    task automatic send(input logic [31:0] w);
        dl_valid_i <= 1'b1;
        dl_data_i  <= w;
        @(posedge ref_clk_i iff dl_ready_o);
    endtask
    // Released data lines toggle so a stale word never looks valid.
    task automatic idle(input int n);
        dl_valid_i <= 1'b0;
        repeat (n) begin
            dl_data_i <= ~dl_data_i;
            @(posedge ref_clk_i);
        end
    endtask
endmodule // rdld_dl_host
`default_nettype wire

// *** tb/rdld_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rdld_regs.vh"
module rdld_props (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        dl_ready_o,
    input wire logic        dl_valid_i,
    input wire logic [31:0] dl_data_i,
    input wire logic        vsync_i,
    input wire logic        host_irq_o,
    input wire logic        fb_flush_o,
    input wire logic        z_flush_o,
    input wire logic        reg_we_o,
    input wire logic [15:0] reg_addr_o,
    input wire logic        pattern_clear_o,
    input wire logic        draw_go_o,
    input wire logic [1:0]  draw_kind_o,
    input wire logic        shape_active_o,
    input wire logic [15:0] bbox_xmin_o,
    input wire logic [15:0] bbox_xmax_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // A bus request that has not yet been answered.
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // A pattern-clear line is started one cycle after the clear pulse.
    sequence pclr_go_s;
        pattern_clear_o ##1 (draw_go_o && draw_kind_o == `RDLD_KIND_LINE);
    endsequence
    wb_answer_a: assert property (wb_req_s |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer held too long");
    irq_pulse_a: assert property (host_irq_o |-> $past(dl_valid_i
        && dl_ready_o && dl_data_i[31:24] == `RDLD_TYPE_INTR))
        else $error("host request without interrupt header");
    flush_pulse_a: assert property (fb_flush_o |-> !z_flush_o
        && $past(dl_valid_i && dl_ready_o && dl_data_i[31:16] ==
        {`RDLD_TYPE_DRAW, `RDLD_CMD_FB_FLUSH}))
        else $error("frame flush without flush header");
    reg_consec_a: assert property (reg_we_o && $past(reg_we_o)
        |-> reg_addr_o == $past(reg_addr_o) + 16'h0001)
        else $error("register writes not consecutive");
    pclr_go_a: assert property (pattern_clear_o |-> pclr_go_s)
        else $error("pattern clear not followed by line start");
    sync_hold_a: assert property (!dl_ready_o && !$past(vsync_i, 2)
        && !wb_cyc_i |=> !dl_ready_o)
        else $error("stream released without vertical sync");
    shape_box_a: assert property (shape_active_o
        |-> $signed(bbox_xmin_o) <= $signed(bbox_xmax_o))
        else $error("bounding rectangle inverted");
    shape_close_a: assert property (draw_go_o && draw_kind_o == `RDLD_KIND_SHAPE
        |-> ##[0:1] !shape_active_o)
        else $error("shape still open after shape end");
endmodule // rdld_props
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rdld_regs.vh"
module tb;
    logic        ref_clk_i = 0, reset_i = 1, vsync_i = 0, wb_we_i = 0;
    logic        wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, dl_valid_i, dl_ready_o;
    logic [7:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 0, vtx_sel_o;
    logic [31:0] wb_dat_i = 0, wb_dat_o, dl_data_i, reg_data_o;
    logic        host_irq_o, fb_flush_o, z_flush_o, reg_we_o, vtx_we_o;
    logic        line_axis_y_o, line_no_end_o, line_anti_alias_o;
    logic        pattern_clear_o, draw_go_o, shape_active_o;
    logic [15:0] reg_addr_o, vtx_x_o, vtx_y_o;
    logic [15:0] bbox_xmin_o, bbox_xmax_o, bbox_ymin_o, bbox_ymax_o;
    logic [31:0] pixel_x_start_o, pixel_y_start_o, pixel_z_value_o;
    logic [31:0] line_pattern_word_o, line_x_start_o, line_x_delta_o;
    logic [31:0] line_y_start_o, line_y_delta_o, q;
    logic [1:0]  draw_kind_o;
    logic [47:0] wq[$];
    logic [4:0]  gq[$];
    logic [35:0] vq[$];
    logic [31:0] lw[$];
    int failures = 0, samples_checked = 0, cycles = 0, t0, n0;
    int n_irq = 0, n_fb = 0, n_z = 0, n_pclr = 0;

    rdld_decoder dut_u (.*);
    rdld_dl_host host_u (.*);
    always #4 ref_clk_i = ~ref_clk_i;

    // Counts pulses and logs writes and starts as seen before each edge.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (host_irq_o) n_irq++;
        if (fb_flush_o) n_fb++;
        if (z_flush_o) n_z++;
        if (pattern_clear_o) n_pclr++;
        if (reg_we_o) wq.push_back({reg_addr_o, reg_data_o});
        if (draw_go_o)
            gq.push_back({draw_kind_o, line_axis_y_o, line_no_end_o,
                          line_anti_alias_o});
        if (vtx_we_o) vq.push_back({vtx_sel_o, vtx_x_o, vtx_y_o});
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [159:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One classic bus cycle; read data is taken at the acknowledging edge.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i}
            <= {2'b11, we, a, d, 4'hF};
        @(posedge ref_clk_i iff wb_ack_o);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge ref_clk_i);
    endtask

    // Sends a list back to back, then lets the pipeline settle.
    task automatic dl(input logic [31:0] w[$]);
        foreach (w[i]) host_u.send(w[i]);
        host_u.idle(4);
    endtask

    task automatic t_regs;
        wb(1'b0, `RDLD_OFS_CTRL, 32'h0);
        check("ctrl reset", q, `RDLD_CTRL_RST);
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h3C, 32'h0);
        check("unmapped read", q, 32'h0);
        wb(1'b1, `RDLD_OFS_CTRL, 32'h0);
        check("ready when off", dl_ready_o, 1'b0);
        wb(1'b1, `RDLD_OFS_CTRL, 32'h1);
        $display("test regs done");
    endtask

    task automatic t_events;
        dl('{32'hFD00_0000, 32'h0500_0000, 32'hFD00_FFFF, 32'h42FF_FFFF,
             32'hFD00_0000, 32'hF0C1_0000, 32'hF0C2_0000, 32'hF001_0000,
             32'hF100_0200, 32'hFF12_3456});
        check("irq count", n_irq, 3);
        check("fb flush", n_fb, 1);
        check("z flush", n_z, 1);
        check("no writes", wq.size(), 0);
        check("no draws", gq.size(), 0);
        dl('{32'hF103_0100, 32'hA, 32'hB, 32'hC});
        check("write count", wq.size(), 3);
        foreach (wq[i])
            check("reg write", wq[i], {16'h0100 + i[15:0], 32'hA + i});
        $display("test events done");
    endtask

    task automatic t_pixel;
        dl('{32'h0000_0000, 32'h11, 32'h22, 32'h0101_0000, 32'h33, 32'h44,
             32'h55});
        check("pixel kind", gq[0][4:3], `RDLD_KIND_PIXEL);
        check("depth kind", gq[1][4:3], `RDLD_KIND_PIXELZ);
        check("pixel regs", {pixel_x_start_o, pixel_y_start_o, pixel_z_value_o},
              {32'h33, 32'h44, 32'h55});
        gq.delete();
        $display("test pixel done");
    endtask

    task automatic t_lines;
        for (int c = -1; c < 16; c++) begin
            lw.push_back({8'h02, c < 0 ? 8'h30 : 8'h20 + c[7:0], 16'h0});
            for (int k = 0; k < 5; k++) lw.push_back((c + 1) * 16 + k);
        end
        dl(lw);
        check("line starts", gq.size(), 16);
        check("pattern clears", n_pclr, 8);
        for (int c = 0; c < 16; c++)
            check("line mode", gq[c], {`RDLD_KIND_LINE, c[0], c[1], c[3]});
        check("line regs", {line_pattern_word_o, line_x_start_o, line_x_delta_o,
              line_y_start_o, line_y_delta_o},
              {32'h100, 32'h101, 32'h102, 32'h103, 32'h104});
        gq.delete();
        $display("test lines done");
    endtask

    task automatic t_vertex;
        dl('{32'h70FF_00F5, 32'h0012_0000, 32'h0034_8000, 32'h71FF_0003,
             32'h0056_0078});
        check("unpacked vertex", vq[0], {4'h5, 16'h0012, 16'h0034});
        check("packed vertex", vq[1], {4'h3, 16'h0078, 16'h0056});
        dl('{32'h70E0_0001, 32'h000A_0000, 32'h0014_0000, 32'h71FF_0002,
             32'hFFFB_0028});
        check("shape open", shape_active_o, 1'b1);
        wb(1'b0, `RDLD_OFS_BBOX_X, 32'h0);
        check("box x", q, 32'h0028_000A);
        wb(1'b0, `RDLD_OFS_BBOX_Y, 32'h0);
        check("box y", q, 32'h0014_FFFB);
        dl('{32'hF0E1_0000});
        check("shape kind", gq[0][4:3], `RDLD_KIND_SHAPE);
        check("shape closed", shape_active_o, 1'b0);
        $display("test vertex done");
    endtask

    task automatic t_sync;
        t0 = cycles;
        dl('{32'hFC00_0000, 32'hFD00_0000});
        check("no wait", cycles - t0, 6);
        n0 = n_irq;
        fork
            dl('{32'hFC00_0001, 32'hFD00_0000});
            begin
                repeat (12) @(posedge ref_clk_i);
                check("held", n_irq, n0);
                vsync_i <= 1'b1;
                repeat (10) @(posedge ref_clk_i);
                vsync_i <= 1'b0;
            end
        join
        check("released", n_irq, n0 + 1);
        $display("test sync done");
    endtask

    // Reset is held for twelve cycles, then every scenario runs in turn.
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        t_regs();
        t_events();
        t_pixel();
        t_lines();
        t_vertex();
        t_sync();
        print_verdict();
    end
endmodule // tb

bind rdld_decoder rdld_props chk_u (.*);
`default_nettype wire
